// >>> design/trs_pkg.sv
// package: constants, states and helpers for the reconfiguration error and reset sequencer
`default_nettype none
package trs_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;  // reconfiguration clock rate
  localparam int CLK_PERIOD_NS = 20;  // one clock period
  localparam int LOCK_WAIT_NS = 4000;  // least wait after frequency lock
  // least time rounds up to whole cycles
  localparam int LOCK_WAIT_CYC = (LOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_PULSE_CYC = 2;  // error pulse length
  localparam int OC_SIM_CYC = 16;  // offset cancellation, reduced model
  localparam int OP_LEN_CYC = 8;  // default length of one operation
  localparam int OP_TIMEOUT_CYC = 64;  // default expected cycle bound
  localparam int CNT_W = 16;  // width of cycle counters
  // ----------------------------------------------------------------
  // mode select encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_CHANNEL = 3'h1;  // channel reconfiguration mode
  localparam logic RST_BUSY = 1'b0;  // busy after reset
  localparam logic RST_ERROR = 1'b0;  // error after reset
  localparam logic RST_XCVR = 1'b1;  // transceiver resets held after reset
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRS_IDLE = 2'b00,  // waiting for a request
    TRS_CHECK = 2'b01,  // legality check cycle
    TRS_RUN = 2'b11,  // operation in flight
    TRS_ERR = 2'b10  // error pulse
  } trs_op_e;
  typedef enum logic [1:0] {
    TRS_S_HOLD = 2'b00,  // all transceiver resets held
    TRS_S_WAITLK = 2'b01,  // tx/rx analog released, wait for lock
    TRS_S_COUNT = 2'b11,  // lock seen, counting the wait
    TRS_S_DONE = 2'b10  // all resets released
  } trs_seq_e;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a request is illegal for the configured options
  function automatic logic trs_illegal(input logic rd, input logic wr, input logic [2:0] mode,
                                       input logic has_rdback, input logic has_ctl);
    trs_illegal = (rd && !has_rdback) || (wr && !has_ctl) || (rd && mode == MODE_CHANNEL);
  endfunction
  // saturating counter step
  function automatic logic [CNT_W-1:0] trs_inc(input logic [CNT_W-1:0] v);
    trs_inc = (v == {CNT_W{1'b1}}) ? v : v + 16'h0001;
  endfunction
endpackage
`default_nettype wire

// >>> design/trs_sync.sv
// module: three-stage pin synchroniser whose output changes once stages two and three agree
`default_nettype none
module trs_sync (
  input wire logic i_clk_sys,  // system clock
  input wire logic i_rst,  // synchronous reset, active high
  input wire logic i_async,  // input from outside the clock domain
  output logic o_sync  // filtered level
);
  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [2:0] stage_reg;  // shift chain
  logic [2:0] stage_next;  // next chain value
  logic out_reg;  // settled level
  logic out_next;  // next settled level

  // next values; stage 0 is read only by stage 1
  always_comb begin
    stage_next = {stage_reg[1:0], i_async};
    out_next = out_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];  // two later stages agree
    end
  end

  // registers only
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stage_reg <= 3'h0;
      out_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;
endmodule
`default_nettype wire

// >>> design/trs_top.sv
// module: reconfiguration error checker, self recovery and transceiver reset sequencer
// Notes on behaviour
// - error output exists only with checking options
// - illegal request caught in two cycles, error two
// - read illegal without any readback outputs
// - write-all illegal without any control inputs
// - read in channel mode is illegal
// - overlong operation abandoned, busy low, error two
// - out-of-range control values raise no error
// - offset cancellation lasts 16 cycles in simulation
// - PLL reset one edge after reconfig done
`default_nettype none
module trs_top #(
  parameter bit P_ILLEGAL_CHECK = 1'b1,  // illegal mode checking option
  parameter bit P_SELF_RECOVERY = 1'b1,  // self recovery option
  parameter bit P_HAS_RDBACK = 1'b1,  // any control readback output configured
  parameter bit P_HAS_CTL = 1'b1,  // any control input configured
  parameter bit P_SIM_MODEL = 1'b1,  // reduced timing model
  parameter int P_OP_LEN = trs_pkg::OP_LEN_CYC,  // cycles an operation normally takes
  parameter int P_TIMEOUT = trs_pkg::OP_TIMEOUT_CYC,  // expected cycle bound
  parameter int P_OC_HW_LEN = 256  // offset cancellation length on hardware
) (
  input wire logic i_clk_sys,  // 50 MHz reconfiguration clock
  input wire logic i_rst,  // synchronous reset, active high
  input wire logic i_read,  // read request, level, same domain
  input wire logic i_write_all,  // write-all request, level, same domain
  input wire logic [2:0] i_mode_sel,  // reconfiguration mode select
  input wire logic i_op_done,  // operation finished, pulse, same domain
  input wire logic i_oc_start,  // start offset cancellation, pulse
  input wire logic i_pll_reconfig_done,  // transceiver PLL reconfig done, same domain
  input wire logic i_seq_start,  // start the reset sequence (steps 1..3 done)
  input wire logic i_rx_freq_locked,  // receiver frequency lock, from pin
  output logic o_busy,  // operation in progress
  output logic o_error,  // error pulse, two cycles
  output logic o_oc_busy,  // offset cancellation running
  output logic o_pll_areset,  // transceiver PLL reset
  output logic o_tx_digital_rst,  // transmit digital reset
  output logic o_rx_analog_rst,  // receive analog reset
  output logic o_rx_digital_rst  // receive digital reset
);
  import trs_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // counters are 16 bits and saturate, so longer bounds could never be reached
  if (P_OP_LEN < 1 || P_TIMEOUT <= P_OP_LEN || P_TIMEOUT >= 65535 ||
      P_OC_HW_LEN < 1 || P_OC_HW_LEN >= 65535) begin : g_bad_counts
    $error("trs_top: unsupported count parameters");
  end

  localparam bit ERR_EN = P_ILLEGAL_CHECK || P_SELF_RECOVERY;  // error output present
  localparam logic [CNT_W-1:0] OC_LEN = P_SIM_MODEL ? CNT_W'(OC_SIM_CYC) : CNT_W'(P_OC_HW_LEN);
  localparam logic [CNT_W-1:0] TMO = CNT_W'(P_TIMEOUT);
  localparam logic [CNT_W-1:0] OPL = CNT_W'(P_OP_LEN);
  localparam logic [CNT_W-1:0] LKW = CNT_W'(LOCK_WAIT_CYC);
  localparam logic [CNT_W-1:0] EPL = CNT_W'(ERR_PULSE_CYC);

  // ----------------------------------------------------------------
  // lock input synchroniser
  // ----------------------------------------------------------------
  logic locked_s;  // settled frequency lock

  trs_sync u_lock_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_rx_freq_locked),
    .o_sync(locked_s)
  );

  // ----------------------------------------------------------------
  // operation control and error
  // ----------------------------------------------------------------
  trs_op_e op_reg;  // operation state
  trs_op_e op_next;
  logic [CNT_W-1:0] op_cnt_reg;  // cycles in the current state
  logic [CNT_W-1:0] op_cnt_next;
  logic busy_reg;  // registered busy
  logic busy_next;
  logic err_reg;  // registered error
  logic err_next;
  logic req;  // any request present

  assign req = i_read || i_write_all;

  // next state: request checked in the cycle after capture, so illegal
  // requests are flagged within two cycles; out-of-range control values are
  // never examined, so they cannot raise error
  always_comb begin
    op_next = op_reg;
    op_cnt_next = trs_inc(op_cnt_reg);
    busy_next = busy_reg;
    err_next = 1'b0;  // error low unless flagged
    case (op_reg)
      TRS_IDLE: begin
        op_cnt_next = '0;
        if (req) begin
          op_next = TRS_CHECK;
          busy_next = 1'b1;
        end
      end
      TRS_CHECK: begin
        op_cnt_next = '0;
        // read without readback, write-all without controls, read in channel mode
        if (P_ILLEGAL_CHECK && trs_illegal(i_read, i_write_all, i_mode_sel, P_HAS_RDBACK, P_HAS_CTL)) begin
          op_next = TRS_ERR;
          busy_next = 1'b0;
          err_next = ERR_EN;
        end else begin
          op_next = TRS_RUN;
        end
      end
      TRS_RUN: begin
        // without self recovery the operation ends at its own length or done
        if (i_op_done || (!P_SELF_RECOVERY && op_cnt_reg + 16'h0001 >= OPL)) begin
          op_next = TRS_IDLE;
          busy_next = 1'b0;
        end else if (P_SELF_RECOVERY && op_cnt_reg + 16'h0001 >= TMO) begin
          op_next = TRS_ERR;  // abandon the overlong operation
          busy_next = 1'b0;
          err_next = 1'b1;
          op_cnt_next = '0;
        end
      end
      TRS_ERR: begin
        // hold error for exactly two cycles
        err_next = ERR_EN && (op_cnt_reg + 16'h0001 < EPL);
        if (op_cnt_reg + 16'h0001 >= EPL) begin
          op_next = TRS_IDLE;
        end
      end
      default: begin
        op_next = TRS_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  // busy and error only move on clock edges
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      op_reg <= TRS_IDLE;
      op_cnt_reg <= '0;
      busy_reg <= RST_BUSY;
      err_reg <= RST_ERROR;
    end else begin
      op_reg <= op_next;
      op_cnt_reg <= op_cnt_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // offset cancellation timer
  // ----------------------------------------------------------------
  logic oc_reg;  // offset cancellation running
  logic oc_next;
  logic [CNT_W-1:0] oc_cnt_reg;  // cycles elapsed
  logic [CNT_W-1:0] oc_cnt_next;

  // power-down must stay low meanwhile; that is the user's duty
  always_comb begin
    oc_next = oc_reg;
    oc_cnt_next = oc_cnt_reg;
    if (!oc_reg) begin
      if (i_oc_start) begin
        oc_next = 1'b1;
        oc_cnt_next = '0;
      end
    end else begin
      oc_cnt_next = trs_inc(oc_cnt_reg);
      if (oc_cnt_reg + 16'h0001 >= OC_LEN) begin
        oc_next = 1'b0;  // 16 cycles in the reduced model
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      oc_reg <= 1'b0;
      oc_cnt_reg <= '0;
    end else begin
      oc_reg <= oc_next;
      oc_cnt_reg <= oc_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // transceiver PLL reset and reset release sequence
  // ----------------------------------------------------------------
  trs_seq_e seq_reg;  // reset sequence state
  trs_seq_e seq_next;
  logic [CNT_W-1:0] lk_cnt_reg;  // cycles since lock
  logic [CNT_W-1:0] lk_cnt_next;
  logic pll_rst_reg;  // transceiver PLL reset
  logic pll_rst_next;
  logic done_d_reg;  // reconfig done, last cycle
  logic tx_rst_reg;
  logic tx_rst_next;
  logic rxa_rst_reg;
  logic rxa_rst_next;
  logic rxd_rst_reg;
  logic rxd_rst_next;

  // resets stay held until the user says PLL and every channel sharing it
  // are reconfigured a new PLL reconfig re-arms the hold
  always_comb begin
    seq_next = seq_reg;
    lk_cnt_next = lk_cnt_reg;
    // PLL reset on the edge after done rises
    pll_rst_next = i_pll_reconfig_done && !done_d_reg;
    case (seq_reg)
      TRS_S_HOLD: begin
        lk_cnt_next = '0;
        if (i_seq_start) begin
          seq_next = TRS_S_WAITLK;
        end
      end
      TRS_S_WAITLK: begin
        lk_cnt_next = '0;
        if (locked_s) begin
          seq_next = TRS_S_COUNT;
        end
      end
      TRS_S_COUNT: begin
        lk_cnt_next = trs_inc(lk_cnt_reg);
        if (!locked_s) begin
          seq_next = TRS_S_WAITLK;  // lock lost, restart the wait
        end else if (lk_cnt_reg + 16'h0001 >= LKW) begin
          seq_next = TRS_S_DONE;  // at least 4 us after lock
        end
      end
      TRS_S_DONE: begin
        lk_cnt_next = '0;
      end
      default: begin
        seq_next = TRS_S_HOLD;
      end
    endcase
    if (i_pll_reconfig_done && !done_d_reg) begin
      seq_next = TRS_S_HOLD;
    end
    tx_rst_next = (seq_next == TRS_S_HOLD);
    rxa_rst_next = (seq_next == TRS_S_HOLD);
    rxd_rst_next = (seq_next != TRS_S_DONE);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      seq_reg <= TRS_S_HOLD;
      lk_cnt_reg <= '0;
      pll_rst_reg <= 1'b0;
      done_d_reg <= 1'b0;
      tx_rst_reg <= RST_XCVR;
      rxa_rst_reg <= RST_XCVR;
      rxd_rst_reg <= RST_XCVR;
    end else begin
      seq_reg <= seq_next;
      lk_cnt_reg <= lk_cnt_next;
      pll_rst_reg <= pll_rst_next;
      done_d_reg <= i_pll_reconfig_done;
      tx_rst_reg <= tx_rst_next;
      rxa_rst_reg <= rxa_rst_next;
      rxd_rst_reg <= rxd_rst_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign o_busy = busy_reg;
  assign o_error = err_reg;
  assign o_oc_busy = oc_reg;
  assign o_pll_areset = pll_rst_reg;
  assign o_tx_digital_rst = tx_rst_reg;
  assign o_rx_analog_rst = rxa_rst_reg;
  assign o_rx_digital_rst = rxd_rst_reg;
endmodule
`default_nettype wire

// >>> testbench/trs_top_asserts.sv
// checker: port timing of the reconfiguration error and reset sequencer
`default_nettype none
module trs_top_asserts
  import trs_pkg::*;
#(
  parameter bit P_ILLEGAL_CHECK = 1'b1,  // checking option
  parameter bit P_HAS_CTL = 1'b1,  // control inputs present
  parameter int P_TIMEOUT = OP_TIMEOUT_CYC  // op cycle bound
) (
  input wire logic i_clk_sys,  // clock
  input wire logic i_rst,  // sync reset
  input wire logic i_read,  // read request
  input wire logic i_write_all,  // write-all request
  input wire logic [2:0] i_mode_sel,  // mode select
  input wire logic i_pll_reconfig_done,  // pll done
  input wire logic i_rx_freq_locked,  // lock pin
  input wire logic o_busy,  // busy
  input wire logic o_error,  // error
  input wire logic o_oc_busy,  // offset cancel
  input wire logic o_pll_areset,  // pll reset
  input wire logic o_tx_digital_rst,  // tx digital
  input wire logic o_rx_analog_rst,  // rx analog
  input wire logic o_rx_digital_rst  // rx digital
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] busy_cnt_reg, busy_cnt_next;  // busy cycles in a row
  logic [CNT_W-1:0] lock_cnt_reg, lock_cnt_next;  // raw lock cycles in a row
  // the raw pin leads the synchroniser, so its count is a safe floor
  always_comb begin
    busy_cnt_next = o_busy ? busy_cnt_reg + 1'b1 : '0;
    lock_cnt_next = i_rx_freq_locked ? lock_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge i_clk_sys) begin
    busy_cnt_reg <= i_rst ? '0 : busy_cnt_next;
    lock_cnt_reg <= i_rst ? '0 : lock_cnt_next;
  end
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_err_two_cyc: assert property ($rose(o_error) |=> o_error ##1 !o_error)
    else $error("error pulse not two cycles");
  a_err_drops_busy: assert property ($rose(o_error) |-> $fell(o_busy))
    else $error("error rose without busy falling");
  a_err_not_busy: assert property (o_error |-> !o_busy)
    else $error("error high while busy");
  a_ill_read: assert property ($rose(o_busy) && i_read && i_mode_sel == MODE_CHANNEL && P_ILLEGAL_CHECK
    |=> o_error) else $error("channel mode read not flagged");
  a_wr_legal: assert property ($rose(o_busy) && i_write_all && !i_read && P_HAS_CTL |=> !o_error)
    else $error("legal write flagged");
  a_busy_bound: assert property (busy_cnt_reg <= P_TIMEOUT + 3)
    else $error("operation outlived its bound");
  a_oc_len: assert property ($rose(o_oc_busy) |-> o_oc_busy[*8] ##1 o_oc_busy[*8] ##1 !o_oc_busy)
    else $error("offset cancel length wrong");
  a_pll_pulse: assert property ($rose(i_pll_reconfig_done) |=> o_pll_areset ##1 !o_pll_areset)
    else $error("pll reset pulse wrong");
  a_pll_holds: assert property ($rose(i_pll_reconfig_done) |=> o_tx_digital_rst && o_rx_analog_rst
    && o_rx_digital_rst) else $error("resets not held after pll update");
  a_rxd_wait: assert property ($fell(o_rx_digital_rst) |-> lock_cnt_reg >= LOCK_WAIT_CYC
    && !o_tx_digital_rst && !o_rx_analog_rst) else $error("rx digital released early");
endmodule
bind trs_top trs_top_asserts #(.P_ILLEGAL_CHECK(P_ILLEGAL_CHECK), .P_HAS_CTL(P_HAS_CTL), .P_TIMEOUT(P_TIMEOUT))
  u_chk (.i_clk_sys, .i_rst, .i_read, .i_write_all, .i_mode_sel, .i_pll_reconfig_done, .i_rx_freq_locked,
  .o_busy, .o_error, .o_oc_busy, .o_pll_areset, .o_tx_digital_rst, .o_rx_analog_rst, .o_rx_digital_rst);
`default_nettype wire

// >>> testbench/trs_top_tb.sv
// testbench: requests, offset cancellation and reset release of the sequencer
`default_nettype none
module trs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import trs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clk_sys, i_rst, i_read, i_write_all, i_op_done, i_oc_start;  // clock, reset, requests
  logic i_pll_reconfig_done, i_seq_start, i_rx_freq_locked;  // pll and sequence
  logic [2:0] i_mode_sel;  // mode select
  logic o_busy, o_error, o_oc_busy, o_pll_areset;  // main outputs
  logic o_tx_digital_rst, o_rx_analog_rst, o_rx_digital_rst;  // transceiver resets
  logic err2, err3;  // reduced-option instances
  logic [7:0] dly;  // partner completion delay
  logic lock_en;  // ask partner for lock
  logic [15:0] c;  // scratch count
  int num_errors = 0;  // mismatches
  int n_checks = 0;  // comparisons
  int exp_err_q[$];  // rule model: expected error cycles per request, in issue order
  // per channel pass: read, write-all, channel mode, stalled (bit k)
  localparam logic [5:0] RD_SET = 6'h2D;
  localparam logic [5:0] WR_SET = 6'h1A;
  localparam logic [5:0] CH_SET = 6'h2E;
  localparam logic [5:0] ZD_SET = 6'h30;
  trs_top DUT (.i_clk_sys, .i_rst, .i_read, .i_write_all, .i_mode_sel, .i_op_done, .i_oc_start,
    .i_pll_reconfig_done, .i_seq_start, .i_rx_freq_locked, .o_busy, .o_error, .o_oc_busy,
    .o_pll_areset, .o_tx_digital_rst, .o_rx_analog_rst, .o_rx_digital_rst);
  // no readback and no control inputs: every request is illegal
  trs_top #(.P_HAS_RDBACK(1'b0), .P_HAS_CTL(1'b0)) DUT2 (.i_clk_sys, .i_rst, .i_read, .i_write_all,
    .i_mode_sel, .i_op_done, .i_oc_start, .i_pll_reconfig_done, .i_seq_start, .i_rx_freq_locked,
    .o_busy(), .o_error(err2), .o_oc_busy(), .o_pll_areset(), .o_tx_digital_rst(),
    .o_rx_analog_rst(), .o_rx_digital_rst());
  // both checking options off: no error may ever show
  trs_top #(.P_ILLEGAL_CHECK(1'b0), .P_SELF_RECOVERY(1'b0)) DUT3 (.i_clk_sys, .i_rst, .i_read,
    .i_write_all, .i_mode_sel, .i_op_done, .i_oc_start, .i_pll_reconfig_done, .i_seq_start,
    .i_rx_freq_locked, .o_busy(), .o_error(err3), .o_oc_busy(), .o_pll_areset(),
    .o_tx_digital_rst(), .o_rx_analog_rst(), .o_rx_digital_rst());
  trs_user_model u_user (.i_clk_sys, .i_busy(o_busy), .i_dly(dly), .i_lock_en(lock_en),
    .o_op_done(i_op_done), .o_locked(i_rx_freq_locked));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one request; the model expects two error cycles for a channel read or a stall
  task automatic op(input logic r, input logic w, input logic [2:0] m, input logic [7:0] d);
    logic [15:0] e1, e2, e3;
    logic bad;
    bad = (r && m == MODE_CHANNEL) || d == 8'h00;
    exp_err_q.push_back(bad ? ERR_PULSE_CYC : 0);
    e1 = '0;
    e2 = '0;
    e3 = '0;
    i_read = r;
    i_write_all = w;
    i_mode_sel = m;
    dly = d;
    @(negedge i_clk_sys);
    check("busy", 16'(o_busy), 16'h1);
    @(negedge i_clk_sys);
    i_read = 1'b0;  // held across the legality check edge
    i_write_all = 1'b0;
    repeat (80) begin
      e1 += 16'(o_error === 1'b1);
      e2 += 16'(err2 === 1'b1);
      e3 += 16'(err3 === 1'b1);
      @(negedge i_clk_sys);
    end
    check("error cycles", e1, 16'(exp_err_q.pop_front()));
    check("error cycles no ports", e2, 16'h2);
    check("error cycles no options", e3, 16'h0);
    check("busy after op", 16'(o_busy), 16'h0);
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // about 735 cycles are needed; some twenty-seven times that means a hang
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
  initial begin
    i_rst = 1'b1;
    i_read = 1'b0;
    i_write_all = 1'b0;
    i_mode_sel = 3'h0;
    i_oc_start = 1'b0;
    i_pll_reconfig_done = 1'b0;
    i_seq_start = 1'b0;
    dly = 8'h00;
    lock_en = 1'b0;
    void'($urandom(32'h567E5134));
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    c = 16'({o_busy, o_error, o_oc_busy, o_pll_areset, o_tx_digital_rst, o_rx_analog_rst, o_rx_digital_rst});
    check("reset values", c, 16'h0007);
    i_pll_reconfig_done = 1'b1;  // pll update comes first
    @(negedge i_clk_sys);
    c = 16'({o_pll_areset, o_tx_digital_rst, o_rx_analog_rst, o_rx_digital_rst});
    check("pll reset and holds", c, 16'h000F);
    @(negedge i_clk_sys);
    check("pll reset end", 16'(o_pll_areset), 16'h0);
    i_pll_reconfig_done = 1'b0;
    for (int k = 0; k < 6; k++) begin  // one pass per channel on the shared pll
      op(RD_SET[k], WR_SET[k], CH_SET[k] ? MODE_CHANNEL : 3'($urandom_range(7, 2)),
        ZD_SET[k] ? 8'h00 : 8'($urandom_range(20, 2)));
    end
    i_oc_start = 1'b1;  // user side never powers the link down while this runs
    c = '0;
    for (int i = 0; i < 30; i++) begin
      @(negedge i_clk_sys);
      i_oc_start = (i == 5);  // a start while running is ignored
      c += 16'(o_oc_busy === 1'b1);
    end
    check("offset cancel cycles", c, 16'(OC_SIM_CYC));
    i_seq_start = 1'b1;  // every channel done, release may begin
    @(negedge i_clk_sys);
    i_seq_start = 1'b0;
    c = 16'({o_tx_digital_rst, o_rx_analog_rst, o_rx_digital_rst});
    check("tx and rx analog released", c, 16'h0001);
    lock_en = 1'b1;
    c = '0;
    while (o_rx_digital_rst === 1'b1 && c < 16'h0190) begin
      @(negedge i_clk_sys);
      c++;
    end
    check("lock wait", 16'(c >= LOCK_WAIT_CYC && c <= LOCK_WAIT_CYC + 12), 16'h1);
    i_pll_reconfig_done = 1'b1;  // a later pll update takes every reset back
    @(negedge i_clk_sys);
    c = 16'({o_tx_digital_rst, o_rx_analog_rst, o_rx_digital_rst});
    check("resets held again", c, 16'h0007);
    conclude();
  end
endmodule
`default_nettype wire

// >>> testbench/trs_user_model.sv
// partner: user-side operation completion and receiver lock source
`default_nettype none
module trs_user_model (
  input wire logic i_clk_sys,  // clock
  input wire logic i_busy,  // controller busy
  input wire logic [7:0] i_dly,  // completion delay, zero stalls
  input wire logic i_lock_en,  // lock wanted
  output logic o_op_done,  // completion pulse
  output logic o_locked  // receiver lock, off-phase
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;  // busy cycles seen
  initial o_op_done = 1'b0;
  initial o_locked = 1'b0;
  // a zero delay never answers, which drives the controller into timeout
  always @(negedge i_clk_sys) begin
    cnt = i_busy ? cnt + 1 : 0;
    o_op_done <= (i_dly != 8'h00) && (cnt == int'(i_dly));
  end
  // lock arrives off the clock phase, like a pin from another domain
  always @(posedge i_clk_sys) begin
    o_locked <= #7 i_lock_en;
  end
endmodule
`default_nettype wire
